// *** hdl/mis_context_shadow.sv ***
// Shadow copies of the CPU context, captured on entry and replayed on return.
`timescale 1ns/100ps
module mis_context_shadow (
	input wire logic clk, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ce, // Clock enable.
	input wire logic save, // Capture the live context.
	input wire logic [7:0] wIn, // Live working register.
	input wire logic [7:0] statusIn, // Live status register.
	input wire logic [7:0] bsrIn, // Live bank select.
	input wire logic [15:0] fsr0In, // Live indirect address 0.
	input wire logic [15:0] fsr1In, // Live indirect address 1.
	input wire logic [7:0] pclathIn, // Live PC high latch.
	input wire logic [7:0] statusLive, // Status for bits not shadowed.
	output logic [7:0] wSh, // Shadow working register.
	output logic [7:0] statusSh, // Status to restore.
	output logic [7:0] bsrSh, // Shadow bank select.
	output logic [15:0] fsr0Sh, // Shadow indirect address 0.
	output logic [15:0] fsr1Sh, // Shadow indirect address 1.
	output logic [7:0] pclathSh // Shadow PC high latch.
);
	logic [7:0] statusKeep_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wSh <= 8'h00;
			statusKeep_r <= 8'h00;
			bsrSh <= 8'h00;
			fsr0Sh <= 16'h0000;
			fsr1Sh <= 16'h0000;
			pclathSh <= 8'h00;
		end else if (ce && save) begin
			wSh <= wIn;
			statusKeep_r <= statusIn & mis_pkg::STATUS_KEEP_MASK;
			bsrSh <= bsrIn;
			fsr0Sh <= fsr0In;
			fsr1Sh <= fsr1In;
			pclathSh <= pclathIn;
		end
	end
	// Timeout and power-down flags are never restored; they follow the live status.
	assign statusSh = statusKeep_r | (statusLive & ~mis_pkg::STATUS_KEEP_MASK);
endmodule // mis_context_shadow

// *** hdl/mis_flag_bank.sv ***
// Sticky flag bank: hardware set wins over software clear.
`timescale 1ns/100ps
module mis_flag_bank #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ce, // Clock enable.
	input wire logic [WIDTH-1:0] setPulse, // Per-bit set events.
	input wire logic [WIDTH-1:0] clrMask, // Per-bit clear requests.
	output logic [WIDTH-1:0] flags // Current flag values.
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gBit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					flags[i] <= 1'b0;
				end else if (ce) begin
					if (setPulse[i]) begin
						flags[i] <= 1'b1;
					end else if (clrMask[i]) begin
						flags[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate
endmodule // mis_flag_bank

// *** hdl/mis_pkg.sv ***
// Constants and types shared by the interrupt sequencer files.
package mis_pkg;
	localparam int NUM_CORE = 8;
	localparam int NUM_PERI = 16;
	localparam int ADDR_W = 4;
	localparam int PC_W = 15;
	localparam logic [14:0] VECTOR_ADDR = 15'h0004;
	localparam logic [ADDR_W-1:0] A_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] A_CORE_EN = 4'h1;
	localparam logic [ADDR_W-1:0] A_PERI_EN_LO = 4'h2;
	localparam logic [ADDR_W-1:0] A_PERI_EN_HI = 4'h3;
	localparam logic [ADDR_W-1:0] A_CORE_FLAG = 4'h4;
	localparam logic [ADDR_W-1:0] A_PERI_FLAG_LO = 4'h5;
	localparam logic [ADDR_W-1:0] A_PERI_FLAG_HI = 4'h6;
	localparam logic [ADDR_W-1:0] A_IRQ_STATUS = 4'h7;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK = 4'h8;
	localparam logic [ADDR_W-1:0] A_SEQ_STATE = 4'h9;
	localparam int GLOBAL_EN_BIT = 7;
	localparam int GROUP_EN_BIT = 6;
	localparam int EV_ENTRY = 0;
	localparam int EV_RETURN = 1;
	localparam int EV_MISSED = 2;
	localparam int NUM_EV = 3;
	localparam logic [1:0] FIRST_QUARTER_PHASE = 2'h0;
	localparam logic [1:0] LAST_QUARTER_PHASE = 2'h3;
	localparam logic [7:0] STATUS_KEEP_MASK = 8'hE7;
	typedef enum logic [3:0] {
		SEQ_RUN = 4'h1,
		SEQ_FLUSH = 4'h2,
		SEQ_VECTOR = 4'h4,
		SEQ_RETURN = 4'h8
	} mis_state_type;
endpackage

// *** hdl/mis_sequencer.sv ***
// Interrupt sequencer: enables, flags, request gating, entry and return sequencing.
// How it works
// - Reset clears all enables, nothing vectors.
// - Vector needs global and individual enable.
// - Peripheral sources also need group enable.
// - Flags set regardless of any enable.
// - Entry flushes, clears global, pushes, saves, vectors.
// - Handler events only set flags.
// - Return pops, restores context, sets global.
// - Pending request taken when global returns.
// - Requests sampled in first quarter phase.
// - Latency follows executing instruction completion.
// - Shadow W, status less TO/PD, BSR, FSR, PCLATH.
// - Core-register sources ignore group enable.
`timescale 1ns/100ps
module mis_sequencer (
	input wire logic clk, // System clock, 10 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ce, // Clock enable; low freezes all state.
	input wire logic [3:0] regAddr, // Register address.
	input wire logic [7:0] regWdata, // Register write data.
	input wire logic regWr, // Register write strobe.
	input wire logic regRd, // Register read strobe.
	output logic [7:0] regRdata, // Read data, valid the cycle after regRd.
	input wire logic [7:0] coreEvent, // Core source event pulses.
	input wire logic [15:0] periEvent, // Peripheral source event pulses.
	input wire logic [1:0] qPhase, // Quarter phase of the instruction cycle.
	input wire logic instrDone, // Executing instruction ends this cycle.
	input wire logic returnFromIrqInstr, // Return instruction executing.
	input wire logic [14:0] pcIn, // Live program counter.
	input wire logic [7:0] wIn, // Live working register.
	input wire logic [7:0] statusIn, // Live status register.
	input wire logic [7:0] bsrIn, // Live bank select.
	input wire logic [15:0] fsr0In, // Live indirect address 0.
	input wire logic [15:0] fsr1In, // Live indirect address 1.
	input wire logic [7:0] pclathIn, // Live PC high latch.
	output logic flushPrefetch, // Discard prefetched instruction, one cycle.
	output logic pushPc, // Push pushData onto the stack, one cycle.
	output logic [14:0] pushData, // Return address to push.
	output logic loadPc, // Load PC with pcLoadValue, one cycle.
	output logic [14:0] pcLoadValue, // Vector address.
	output logic popPc, // Pop return address, one cycle.
	output logic restoreCtx, // Restore context from the shadow outputs, one cycle.
	output logic [7:0] wRestore, // Working register to restore.
	output logic [7:0] statusRestore, // Status to restore.
	output logic [7:0] bsrRestore, // Bank select to restore.
	output logic [15:0] fsr0Restore, // Indirect address 0 to restore.
	output logic [15:0] fsr1Restore, // Indirect address 1 to restore.
	output logic [7:0] pclathRestore, // PC high latch to restore.
	output logic irqPending, // Gated request is present.
	output logic irq // Level interrupt from sticky sequencer events.
);
	logic [7:0] control_r;
	logic [7:0] coreEn_r;
	logic [15:0] periEn_r;
	logic [7:0] coreFlag;
	logic [15:0] periFlag;
	logic [7:0] coreClr;
	logic [15:0] periClr;
	logic [2:0] evStatus;
	logic [2:0] evSet;
	logic [2:0] evClr;
	logic [2:0] evMask_r;
	logic [7:0] coreEvSync1_r, coreEvSync2_r;
	logic [15:0] periEvSync1_r, periEvSync2_r;
	logic request;
	logic sampled_r;
	logic saveCtx;
	logic [7:0] wSh, statusSh, bsrSh, pclathSh;
	logic [15:0] fsr0Sh, fsr1Sh;
	mis_pkg::mis_state_type state_r, state_nxt;
	logic globalEn;
	logic groupEn;

	assign globalEn = control_r[mis_pkg::GLOBAL_EN_BIT];
	assign groupEn = control_r[mis_pkg::GROUP_EN_BIT];

	// Events come from other logic or pins, so they are synchronised first.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			coreEvSync1_r <= 8'h00;
			coreEvSync2_r <= 8'h00;
			periEvSync1_r <= 16'h0000;
			periEvSync2_r <= 16'h0000;
		end else if (ce) begin
			coreEvSync1_r <= coreEvent;
			coreEvSync2_r <= coreEvSync1_r;
			periEvSync1_r <= periEvent;
			periEvSync2_r <= periEvSync1_r;
		end
	end

	assign coreClr = (regWr && regAddr == mis_pkg::A_CORE_FLAG) ? ~regWdata : 8'h00;
	assign periClr = {(regWr && regAddr == mis_pkg::A_PERI_FLAG_HI) ? ~regWdata : 8'h00,
		(regWr && regAddr == mis_pkg::A_PERI_FLAG_LO) ? ~regWdata : 8'h00};

	// Flags follow events with no enable in the path.
	mis_flag_bank #(.WIDTH(mis_pkg::NUM_CORE)) uCoreFlags (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.setPulse(coreEvSync2_r),
		.clrMask(coreClr),
		.flags(coreFlag)
	);

	mis_flag_bank #(.WIDTH(mis_pkg::NUM_PERI)) uPeriFlags (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.setPulse(periEvSync2_r),
		.clrMask(periClr),
		.flags(periFlag)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			coreEn_r <= 8'h00;
			periEn_r <= 16'h0000;
			evMask_r <= 3'h0;
		end else if (ce && regWr) begin
			case (regAddr)
				mis_pkg::A_CORE_EN: coreEn_r <= regWdata;
				mis_pkg::A_PERI_EN_LO: periEn_r[7:0] <= regWdata;
				mis_pkg::A_PERI_EN_HI: periEn_r[15:8] <= regWdata;
				mis_pkg::A_IRQ_MASK: evMask_r <= regWdata[2:0];
				default: ;
			endcase
		end
	end

	// Global enable: software writes, entry clears, return sets.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			control_r <= 8'h00;
		end else if (ce) begin
			if (state_r == mis_pkg::SEQ_FLUSH) begin
				control_r[mis_pkg::GLOBAL_EN_BIT] <= 1'b0;
			end else if (state_r == mis_pkg::SEQ_RETURN) begin
				control_r[mis_pkg::GLOBAL_EN_BIT] <= 1'b1;
			end else if (regWr && regAddr == mis_pkg::A_CONTROL) begin
				control_r[mis_pkg::GLOBAL_EN_BIT] <= regWdata[mis_pkg::GLOBAL_EN_BIT];
			end
			if (regWr && regAddr == mis_pkg::A_CONTROL) begin
				control_r[mis_pkg::GROUP_EN_BIT] <= regWdata[mis_pkg::GROUP_EN_BIT];
			end
		end
	end

	// Core sources skip the group enable; peripheral ones need it.
	assign request = globalEn && (|(coreFlag & coreEn_r)
		|| (groupEn && |(periFlag & periEn_r)));

	// Sample once per instruction cycle in the first quarter.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sampled_r <= 1'b0;
		end else if (ce) begin
			// A request withdrawn before entry is dropped; it stays pending only while it stands.
			if (state_r != mis_pkg::SEQ_RUN || !request) begin
				sampled_r <= 1'b0;
			end else if (qPhase == mis_pkg::FIRST_QUARTER_PHASE && request) begin
				sampled_r <= 1'b1;
			end
		end
	end

	// Entry waits for the current instruction to finish, so latency varies.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mis_pkg::SEQ_RUN: begin
				if (returnFromIrqInstr) begin
					state_nxt = mis_pkg::SEQ_RETURN;
				end else if (sampled_r && request && instrDone) begin
					state_nxt = mis_pkg::SEQ_FLUSH;
				end
			end
			mis_pkg::SEQ_FLUSH: state_nxt = mis_pkg::SEQ_VECTOR;
			mis_pkg::SEQ_VECTOR: state_nxt = mis_pkg::SEQ_RUN;
			mis_pkg::SEQ_RETURN: state_nxt = mis_pkg::SEQ_RUN;
			default: state_nxt = mis_pkg::SEQ_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= mis_pkg::SEQ_RUN;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	assign saveCtx = ce && state_r == mis_pkg::SEQ_FLUSH;

	mis_context_shadow uShadow (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.save(saveCtx),
		.wIn(wIn),
		.statusIn(statusIn),
		.bsrIn(bsrIn),
		.fsr0In(fsr0In),
		.fsr1In(fsr1In),
		.pclathIn(pclathIn),
		.statusLive(statusIn),
		.wSh(wSh),
		.statusSh(statusSh),
		.bsrSh(bsrSh),
		.fsr0Sh(fsr0Sh),
		.fsr1Sh(fsr1Sh),
		.pclathSh(pclathSh)
	);

	// CPU-facing strobes, registered.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flushPrefetch <= 1'b0;
			pushPc <= 1'b0;
			pushData <= 15'h0000;
			loadPc <= 1'b0;
			pcLoadValue <= 15'h0000;
			popPc <= 1'b0;
			restoreCtx <= 1'b0;
		end else if (ce) begin
			flushPrefetch <= state_nxt == mis_pkg::SEQ_FLUSH;
			pushPc <= state_r == mis_pkg::SEQ_FLUSH;
			if (state_r == mis_pkg::SEQ_FLUSH) begin
				pushData <= pcIn;
			end
			loadPc <= state_r == mis_pkg::SEQ_FLUSH;
			pcLoadValue <= mis_pkg::VECTOR_ADDR;
			popPc <= state_r == mis_pkg::SEQ_RETURN;
			restoreCtx <= state_r == mis_pkg::SEQ_RETURN;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wRestore <= 8'h00;
			statusRestore <= 8'h00;
			bsrRestore <= 8'h00;
			fsr0Restore <= 16'h0000;
			fsr1Restore <= 16'h0000;
			pclathRestore <= 8'h00;
			irqPending <= 1'b0;
		end else if (ce) begin
			wRestore <= wSh;
			statusRestore <= statusSh;
			bsrRestore <= bsrSh;
			fsr0Restore <= fsr0Sh;
			fsr1Restore <= fsr1Sh;
			pclathRestore <= pclathSh;
			irqPending <= request;
		end
	end

	// Sequencer events for the sticky status register.
	assign evSet[mis_pkg::EV_ENTRY] = state_r == mis_pkg::SEQ_FLUSH;
	assign evSet[mis_pkg::EV_RETURN] = state_r == mis_pkg::SEQ_RETURN;
	assign evSet[mis_pkg::EV_MISSED] = !globalEn && |(coreFlag & coreEn_r);
	assign evClr = (regWr && regAddr == mis_pkg::A_IRQ_STATUS) ? regWdata[2:0] : 3'h0;

	mis_flag_bank #(.WIDTH(mis_pkg::NUM_EV)) uEvFlags (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.setPulse(evSet),
		.clrMask(evClr),
		.flags(evStatus)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(evStatus & evMask_r);
		end
	end

	// Read data stands in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdata <= 8'h00;
		end else if (ce) begin
			if (regRd) begin
				case (regAddr)
					mis_pkg::A_CONTROL: regRdata <= control_r;
					mis_pkg::A_CORE_EN: regRdata <= coreEn_r;
					mis_pkg::A_PERI_EN_LO: regRdata <= periEn_r[7:0];
					mis_pkg::A_PERI_EN_HI: regRdata <= periEn_r[15:8];
					mis_pkg::A_CORE_FLAG: regRdata <= coreFlag;
					mis_pkg::A_PERI_FLAG_LO: regRdata <= periFlag[7:0];
					mis_pkg::A_PERI_FLAG_HI: regRdata <= periFlag[15:8];
					mis_pkg::A_IRQ_STATUS: regRdata <= {5'h00, evStatus};
					mis_pkg::A_IRQ_MASK: regRdata <= {5'h00, evMask_r};
					mis_pkg::A_SEQ_STATE: regRdata <= {4'h0, state_r};
					default: regRdata <= 8'h00;
				endcase
			end else begin
				regRdata <= 8'h00;
			end
		end
	end
endmodule // mis_sequencer

// *** test/mis_cpu_model.sv ***
// Behavioural model of the CPU fetch and execute pipeline.
`timescale 1ns/100ps
module mis_cpu_model (
	input wire logic clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic doRet, // Bench asks for a return.
	input wire logic pushPc, // Push request.
	input wire logic [14:0] pushData, // Pushed address.
	input wire logic loadPc, // Load request.
	input wire logic [14:0] pcLoadValue, // Vector.
	input wire logic popPc, // Pop request.
	output logic [1:0] qPhase, // Quarter phase.
	output logic instrDone, // Instruction ends.
	output logic returnFromIrqInstr, // Return executing.
	output logic [14:0] pcIn // Program counter.
);
	logic [14:0] stack [0:7];
	logic [2:0] sp;
	logic secondCycle;
	// Odd addresses hold two-cycle instructions, so the entry delay varies.
	assign instrDone = qPhase == mis_pkg::LAST_QUARTER_PHASE && (!pcIn[0] || secondCycle);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			qPhase <= 2'h0;
			secondCycle <= 1'b0;
			returnFromIrqInstr <= 1'b0;
			pcIn <= 15'h0100;
			sp <= 3'h0;
		end else begin
			qPhase <= qPhase + 2'h1;
			returnFromIrqInstr <= doRet;
			if (qPhase == mis_pkg::LAST_QUARTER_PHASE) begin
				secondCycle <= pcIn[0] && !secondCycle;
			end
			if (loadPc) begin
				pcIn <= pcLoadValue;
			end else if (popPc) begin
				pcIn <= stack[sp - 3'h1];
			end else if (instrDone) begin
				pcIn <= pcIn + 15'h1;
			end
			if (pushPc) begin
				stack[sp] <= pushData;
				sp <= sp + 3'h1;
			end else if (popPc) begin
				sp <= sp - 3'h1;
			end
		end
	end
endmodule // mis_cpu_model

// *** test/mis_sequencer_monitor.sv ***
// Concurrent checks on the interrupt sequencer ports.
`timescale 1ns/100ps
module mis_sequencer_monitor (
	input wire logic clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic instrDone, // Instruction ends.
	input wire logic returnFromIrqInstr, // Return executing.
	input wire logic [7:0] statusIn, // Live status.
	input wire logic flushPrefetch, // Flush pulse.
	input wire logic pushPc, // Push pulse.
	input wire logic loadPc, // Load pulse.
	input wire logic [14:0] pcLoadValue, // Vector.
	input wire logic popPc, // Pop pulse.
	input wire logic restoreCtx, // Restore pulse.
	input wire logic [7:0] statusRestore // Status to restore.
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_vector;
		pushPc && loadPc && pcLoadValue == mis_pkg::VECTOR_ADDR;
	endsequence
	sequence s_entry;
		flushPrefetch ##1 s_vector;
	endsequence
	a_entry_steps: assert property (flushPrefetch |-> s_entry) else $error("entry steps wrong");
	a_load_after_flush: assert property (loadPc |-> $past(flushPrefetch)) else $error("load without flush");
	a_flush_after_done: assert property (flushPrefetch |-> $past(instrDone)) else $error("flush mid instruction");
	a_flush_single: assert property (flushPrefetch |=> !flushPrefetch && !popPc) else $error("flush too long");
	a_return_steps: assert property (popPc |-> restoreCtx && $past(returnFromIrqInstr, 2)) else $error("return wrong");
	a_pop_single: assert property (popPc |=> !popPc) else $error("pop too long");
	a_status_live: assert property (restoreCtx |-> statusRestore[4:3] == $past(statusIn[4:3])) else $error("status bits");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !flushPrefetch && !loadPc && !popPc) else $error("busy in reset");
endmodule // mis_sequencer_monitor
bind mis_sequencer mis_sequencer_monitor mis_sequencer_monitor_inst (.clk(clk), .rst(rst), .instrDone(instrDone),
	.returnFromIrqInstr(returnFromIrqInstr), .statusIn(statusIn), .flushPrefetch(flushPrefetch), .pushPc(pushPc),
	.loadPc(loadPc), .pcLoadValue(pcLoadValue), .popPc(popPc), .restoreCtx(restoreCtx),
	.statusRestore(statusRestore));

// *** test/tb.sv ***
// Self-checking bench for the interrupt sequencer.
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb;
	logic clk, rst, regWr, regRd, doRet, flushPrefetch, pushPc, loadPc, popPc, restoreCtx, irqPending, irq, instrDone;
	logic returnFromIrqInstr, got, ce;
	logic [1:0] qPhase;
	logic [3:0] regAddr;
	logic [7:0] regWdata, regRdata, coreEvent, wIn, statusIn, wRestore, statusRestore, bsrRestore, pclathRestore;
	logic [15:0] periEvent, fsr0Restore, fsr1Restore;
	logic [14:0] pcIn, pushData, pcLoadValue, retPc;
	int errors = 0;
	int num_checks = 0;
	mis_sequencer mis_sequencer_inst (.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .coreEvent(coreEvent), .periEvent(periEvent),
		.qPhase(qPhase), .instrDone(instrDone), .returnFromIrqInstr(returnFromIrqInstr), .pcIn(pcIn), .wIn(wIn),
		.statusIn(statusIn), .bsrIn(8'h1E), .fsr0In(16'h1234), .fsr1In(16'h5678), .pclathIn(8'h03),
		.flushPrefetch(flushPrefetch), .pushPc(pushPc), .pushData(pushData), .loadPc(loadPc),
		.pcLoadValue(pcLoadValue), .popPc(popPc), .restoreCtx(restoreCtx), .wRestore(wRestore),
		.statusRestore(statusRestore), .bsrRestore(bsrRestore), .fsr0Restore(fsr0Restore),
		.fsr1Restore(fsr1Restore), .pclathRestore(pclathRestore), .irqPending(irqPending), .irq(irq));
	mis_cpu_model mis_cpu_model_inst (.clk(clk), .rst(rst), .doRet(doRet), .pushPc(pushPc), .pushData(pushData),
		.loadPc(loadPc), .pcLoadValue(pcLoadValue), .popPc(popPc), .qPhase(qPhase), .instrDone(instrDone),
		.returnFromIrqInstr(returnFromIrqInstr), .pcIn(pcIn));
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 `CHK("regRdata", e, regRdata)
	endtask
	task automatic ev(input logic [7:0] c, input logic [15:0] p);
		@(posedge clk);
		coreEvent <= c;
		periEvent <= p;
		@(posedge clk);
		coreEvent <= 8'h00;
		periEvent <= 16'h0000;
		repeat (4) @(posedge clk);
	endtask
	// Waits a bounded time for an entry; on one, checks the vector load.
	task automatic entry(input int n, input logic want);
		got = 1'b0;
		for (int i = 0; i < n && !got; i++) begin
			@(posedge clk);
			#1 got = flushPrefetch;
		end
		`CHK("entry", want, got)
		if (want && !got) print_verdict();
		if (got) begin
			retPc = pcIn;
			repeat (2) @(posedge clk);
			#1 `CHK("pcIn", mis_pkg::VECTOR_ADDR, pcIn)
		end
	endtask
	task automatic ret(input logic [7:0] st);
		got = 1'b0;
		@(posedge clk);
		doRet <= 1'b1;
		@(posedge clk);
		doRet <= 1'b0;
		for (int i = 0; i < 8 && !got; i++) begin
			@(posedge clk);
			#1 got = popPc;
		end
		`CHK("pop", 1'b1, got)
		if (!got) print_verdict();
		`CHK("wRestore", 8'hA5, wRestore)
		`CHK("statusRestore", st, statusRestore)
		`CHK("bsrRestore", 8'h1E, bsrRestore)
		`CHK("fsr0Restore", 16'h1234, fsr0Restore)
		`CHK("fsr1Restore", 16'h5678, fsr1Restore)
		`CHK("pclathRestore", 8'h03, pclathRestore)
		@(posedge clk);
		#1 `CHK("returnPc", retPc, pcIn)
	endtask
	task automatic t_reset();
		rd(mis_pkg::A_CONTROL, 8'h00);
		rd(mis_pkg::A_CORE_EN, 8'h00);
		rd(4'hF, 8'h00);
	endtask
	task automatic t_flags();
		ev(8'h04, 16'h0200);
		rd(mis_pkg::A_CORE_FLAG, 8'h04);
		rd(mis_pkg::A_PERI_FLAG_HI, 8'h02);
		`CHK("irqPending", 1'b0, irqPending)
		entry(20, 1'b0);
		wr(mis_pkg::A_CORE_FLAG, 8'h00);
	endtask
	task automatic t_group();
		wr(mis_pkg::A_PERI_EN_HI, 8'h02);
		wr(mis_pkg::A_CONTROL, 8'h80);
		entry(40, 1'b0);
		wr(mis_pkg::A_CONTROL, 8'hC0);
		@(posedge clk);
		#1 `CHK("irqPending", 1'b1, irqPending)
		entry(40, 1'b1);
		rd(mis_pkg::A_CONTROL, 8'h40);
		@(posedge clk);
		wIn <= 8'h3C;
		statusIn <= 8'h00;
		wr(mis_pkg::A_CORE_EN, 8'h01);
		ev(8'h01, 16'h0000);
		entry(20, 1'b0);
		rd(mis_pkg::A_CORE_FLAG, 8'h01);
		wr(mis_pkg::A_CORE_FLAG, 8'h00);
		wr(mis_pkg::A_PERI_FLAG_HI, 8'h00);
		ret(8'h07);
		rd(mis_pkg::A_CONTROL, 8'hC0);
		@(posedge clk);
		wIn <= 8'hA5;
		statusIn <= 8'h1F;
	endtask
	task automatic t_pending();
		wr(mis_pkg::A_CONTROL, 8'h00);
		ev(8'h01, 16'h0000);
		entry(40, 1'b0);
		wr(mis_pkg::A_CONTROL, 8'h80);
		entry(40, 1'b1);
		wr(mis_pkg::A_CORE_FLAG, 8'h00);
		ret(8'h1F);
	endtask
	task automatic t_irq();
		wr(mis_pkg::A_IRQ_MASK, 8'h00);
		@(posedge clk);
		#1 `CHK("irq", 1'b0, irq)
		rd(mis_pkg::A_IRQ_STATUS, 8'h07);
		wr(mis_pkg::A_IRQ_MASK, 8'h01);
		@(posedge clk);
		#1 `CHK("irq", 1'b1, irq)
		wr(mis_pkg::A_IRQ_STATUS, 8'h07);
		@(posedge clk);
		#1 `CHK("irq", 1'b0, irq)
		rd(mis_pkg::A_IRQ_STATUS, 8'h00);
	endtask
	// A write while the clock enable is low must leave the register untouched.
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'b0;
		wr(mis_pkg::A_CORE_EN, 8'hFF);
		@(posedge clk);
		ce <= 1'b1;
		rd(mis_pkg::A_CORE_EN, 8'h00);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{regWr, regRd, doRet, regAddr, regWdata, coreEvent, periEvent} = '0;
		ce = 1'b1;
		wIn = 8'hA5;
		statusIn = 8'h1F;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_freeze();
		t_flags();
		t_group();
		t_pending();
		t_irq();
		print_verdict();
	end
endmodule // tb
